//--- include/imrm_defines.svh
// register map constants for the input module register bank
// assumes a word-addressed register port, 16-bit data, one clock
// Behaviour
// RULE1 - bit 5 flags input beyond hardware limits
// RULE2 - bit 4 flags amplitude below start scale
// RULE3 - bit 3 flags amplitude above end scale
// RULE4 - bit 2 burn-out only when enabled, out-of-range
// RULE5 - bit 1 flags junction fault on thermocouple
// RULE6 - bit 0 flags parameter memory data loss
// RULE7 - rejection field: 50Hz, 60Hz, none; reset 00
// RULE8 - burn-out enabled fault forces fault output value
// RULE9 - filter byte: 0 off, 1..19 strength
// RULE10 - input type code 0..23, default zero
// RULE11 - address high byte 1..255, default 1
// RULE12 - switches all off: address from memory
// RULE13 - read-only words ignore writes; unused bits zero
`ifndef IMRM_DEFINES_SVH
`define IMRM_DEFINES_SVH

// ************************************************
// register offsets
// ************************************************
`define IMRM_OFF_IDENT    16'h9C41
`define IMRM_OFF_FW       16'h9C42
`define IMRM_OFF_INTYPE   16'h9C43
`define IMRM_OFF_FILTER   16'h9C45
`define IMRM_OFF_REJECT   16'h9C46
`define IMRM_OFF_ADDR     16'h9C61
`define IMRM_OFF_ERR      16'h9C85

// ************************************************
// fields and reset values
// ************************************************
`define IMRM_ERR_OVER     5
`define IMRM_ERR_BELOW    4
`define IMRM_ERR_ABOVE    3
`define IMRM_ERR_BURN     2
`define IMRM_ERR_CJ       1
`define IMRM_ERR_MEM      0
`define IMRM_FILTER_MAX   8'h13
`define IMRM_INTYPE_MAX   16'h0017
`define IMRM_TC_FIRST     16'h0003
`define IMRM_TC_LAST      16'h000A
`define IMRM_REJ_50HZ     2'h0
`define IMRM_REJ_60HZ     2'h1
`define IMRM_REJ_NONE     2'h2
`define IMRM_ADDR_RESET   8'h01
`define IMRM_ADDR_MIN     8'h01
`define IMRM_ADDR_MAX     8'hFF
`define IMRM_PARITY_RESET 8'h00
`define IMRM_INTYPE_RESET 16'h0000
`define IMRM_FILTER_RESET 8'h00
`define IMRM_CJ_RESET     1'h0
`define IMRM_BURN_RESET   1'h0
// identity and firmware words below are arbitrary values
`define IMRM_TYPE_CODE    8'h5A
`define IMRM_MOD_VERSION  8'h01
`define IMRM_FW_CODE      16'h0100

`endif

//--- include/imrm_pkg.sv
// types shared by the input module register bank
// assumes nothing beyond the defines header
package imrm_pkg;
   typedef enum logic [1:0] {
      IMRM_REJ_50 = 2'h0,
      IMRM_REJ_60 = 2'h1,
      IMRM_REJ_OFF = 2'h2
   } imrm_reject_t;
   typedef logic [15:0] imrm_word_t;
endpackage : imrm_pkg

//--- rtl/imrm_err_flags.sv
// error word generation from acquisition status levels
// assumes status inputs synchronous to ref_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "imrm_defines.svh"
module imrm_err_flags (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   // acquisition status
   input  wire logic             over_hw_i,
   input  wire logic             below_ss_i,
   input  wire logic             above_es_i,
   input  wire logic             cj_fail_i,
   input  wire logic             mem_loss_i,
   // configuration
   input  wire logic             burn_en_i,
   input  wire logic             tc_sel_i,
   // result
   output imrm_pkg::imrm_word_t  err_o
);
   import imrm_pkg::*;
   wire logic out_range = below_ss_i | above_es_i;
   imrm_word_t next_err;
   always_comb begin
      next_err = 16'h0000;                               // RULE13
      next_err[`IMRM_ERR_OVER]  = over_hw_i;             // RULE1
      next_err[`IMRM_ERR_BELOW] = below_ss_i;            // RULE2
      next_err[`IMRM_ERR_ABOVE] = above_es_i;            // RULE3
      next_err[`IMRM_ERR_BURN]  = burn_en_i & out_range; // RULE4
      next_err[`IMRM_ERR_CJ]    = tc_sel_i & cj_fail_i;  // RULE5
      next_err[`IMRM_ERR_MEM]   = mem_loss_i;            // RULE6
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_o <= 16'h0000;
      end else begin
         err_o <= next_err;
      end
   end
endmodule : imrm_err_flags
`default_nettype wire

//--- rtl/imrm_regs.sv
// register bank of the process-input module
// assumes a decoded word port from the serial protocol engine
`timescale 1ns/100ps
`default_nettype none
`include "imrm_defines.svh"
module imrm_regs (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // register port
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [15:0]       reg_addr_i,
   input  wire imrm_pkg::imrm_word_t reg_wdata_i,
   output imrm_pkg::imrm_word_t   reg_rdata_o,
   output logic                   reg_ack_o,
   output logic                   reg_err_o,
   // address switches and stored parameters
   input  wire logic [5:0]        addr_sw_i,
   input  wire logic [7:0]        mem_addr_i,
   input  wire logic              mem_load_i,
   // acquisition status
   input  wire logic              over_hw_i,
   input  wire logic              below_ss_i,
   input  wire logic              above_es_i,
   input  wire logic              cj_fail_i,
   input  wire logic              mem_loss_i,
   // fault input and configuration out
   input  wire logic              fault_i,
   output logic [7:0]             node_addr_o,
   output logic                   addr_from_mem_o,
   output logic [15:0]            input_type_o,
   output logic [7:0]             filter_o,
   output logic                   cj_comp_o,
   output imrm_pkg::imrm_reject_t reject_o,
   output logic                   force_fault_o
);
   import imrm_pkg::*;

   // ************************************************
   // storage
   // ************************************************
   imrm_word_t in_type;
   logic [7:0] filt;
   logic       cj_en;
   logic [1:0] rej;
   logic       burn_en;
   logic [7:0] mem_addr;
   logic [7:0] parity;
   imrm_word_t err_word;

   // ************************************************
   // helpers
   // ************************************************
   // one compare per word keeps the decode table flat
   function automatic logic imrm_hit(input logic [15:0] addr,
                                     input logic [15:0] off);
      imrm_hit = (addr == off);
   endfunction : imrm_hit

   // inclusive span test, shared by value checks and type decode
   function automatic logic imrm_in_span(input logic [15:0] val,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      imrm_in_span = (val >= lo) && (val <= hi);
   endfunction : imrm_in_span

   // ************************************************
   // decode
   // ************************************************
   wire logic hit_id  = imrm_hit(reg_addr_i, `IMRM_OFF_IDENT);
   wire logic hit_fw  = imrm_hit(reg_addr_i, `IMRM_OFF_FW);
   wire logic hit_ty  = imrm_hit(reg_addr_i, `IMRM_OFF_INTYPE);
   wire logic hit_fi  = imrm_hit(reg_addr_i, `IMRM_OFF_FILTER);
   wire logic hit_rj  = imrm_hit(reg_addr_i, `IMRM_OFF_REJECT);
   wire logic hit_ad  = imrm_hit(reg_addr_i, `IMRM_OFF_ADDR);
   wire logic hit_er  = imrm_hit(reg_addr_i, `IMRM_OFF_ERR);
   wire logic hit_any = hit_id | hit_fw | hit_ty | hit_fi
                        | hit_rj | hit_ad | hit_er;
   // out-of-range values refused so the field never holds an illegal code
   wire logic ty_ok = imrm_in_span(reg_wdata_i, 16'h0000,
                                   `IMRM_INTYPE_MAX);
   wire logic fi_ok = imrm_in_span({8'h00, reg_wdata_i[7:0]}, 16'h0000,
                                   {8'h00, `IMRM_FILTER_MAX});
   wire logic rj_ok = reg_wdata_i[9:8] <= `IMRM_REJ_NONE;
   wire logic ad_ok = imrm_in_span({8'h00, reg_wdata_i[15:8]},
                                   {8'h00, `IMRM_ADDR_MIN},
                                   {8'h00, `IMRM_ADDR_MAX});
   wire logic wr_ty = reg_wr_i & hit_ty & ty_ok;
   wire logic wr_fi = reg_wr_i & hit_fi & fi_ok;
   wire logic wr_rj = reg_wr_i & hit_rj & rj_ok;
   wire logic wr_ad = reg_wr_i & hit_ad & ad_ok;
   // read-only words answer a write with an error only
   wire logic wr_bad = reg_wr_i & (~hit_any | hit_id | hit_fw | hit_er
                       | (hit_ty & ~ty_ok) | (hit_fi & ~fi_ok)
                       | (hit_rj & ~rj_ok) | (hit_ad & ~ad_ok)); // RULE13
   wire logic rd_bad = reg_rd_i & ~hit_any;
   wire logic sw_off = addr_sw_i == 6'h00;
   wire logic tc_sel = imrm_in_span(in_type, `IMRM_TC_FIRST,
                                    `IMRM_TC_LAST);

   // read words; unused bits tied low
   wire imrm_word_t id_word   = {`IMRM_TYPE_CODE, `IMRM_MOD_VERSION};
   wire imrm_word_t filt_word = {7'h00, cj_en, filt};              // RULE13
   wire imrm_word_t rej_word  = {6'h00, rej, 7'h00, burn_en};      // RULE13
   wire imrm_word_t addr_word = {mem_addr, parity};

   wire imrm_word_t rd_mux =
      hit_id ? id_word :
      hit_fw ? `IMRM_FW_CODE :
      hit_ty ? in_type :
      hit_fi ? filt_word :
      hit_rj ? rej_word :
      hit_ad ? addr_word :
      hit_er ? err_word : 16'h0000;

   wire logic [7:0] next_node = sw_off ? mem_addr           // RULE12
                                       : {2'h0, addr_sw_i};
   // registered answer, one cycle behind the strobe
   wire imrm_word_t next_rdata = reg_rd_i ? rd_mux : 16'h0000;
   wire logic       next_ack   = reg_rd_i | reg_wr_i;
   wire logic       next_err   = rd_bad | wr_bad;
   wire logic       next_force = burn_en & fault_i;                // RULE8

   // ************************************************
   // error word
   // ************************************************
   imrm_err_flags i_imrm_err_flags (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .over_hw_i  (over_hw_i),
      .below_ss_i (below_ss_i),
      .above_es_i (above_es_i),
      .cj_fail_i  (cj_fail_i),
      .mem_loss_i (mem_loss_i),
      .burn_en_i  (burn_en),
      .tc_sel_i   (tc_sel),
      .err_o      (err_word)
   );

   // ************************************************
   // writable fields
   // ************************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_type <= `IMRM_INTYPE_RESET;
      end else if (wr_ty) begin
         in_type <= reg_wdata_i;                            // RULE10
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt  <= `IMRM_FILTER_RESET;
         cj_en <= `IMRM_CJ_RESET;
      end else if (wr_fi) begin
         filt  <= reg_wdata_i[7:0];                         // RULE9
         cj_en <= reg_wdata_i[8];
      end
   end

   // a refused rejection code leaves the burn-out enable alone as well
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rej     <= `IMRM_REJ_50HZ;
         burn_en <= `IMRM_BURN_RESET;
      end else if (wr_rj) begin
         rej     <= reg_wdata_i[9:8];                       // RULE7
         burn_en <= reg_wdata_i[0];                         // RULE8
      end
   end

   // stored address: a memory load of a nonzero address wins over a bus write in the same cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_addr <= `IMRM_ADDR_RESET;
         parity   <= `IMRM_PARITY_RESET;
      end else if (mem_load_i && mem_addr_i != 8'h00) begin
         mem_addr <= mem_addr_i;                            // RULE11
      end else if (wr_ad) begin
         mem_addr <= reg_wdata_i[15:8];                     // RULE11
         parity   <= reg_wdata_i[7:0];
      end
   end

   // ************************************************
   // registered outputs
   // ************************************************
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
         reg_ack_o   <= 1'b0;
         reg_err_o   <= 1'b0;
      end else begin
         reg_rdata_o <= next_rdata;
         reg_ack_o   <= next_ack;
         reg_err_o   <= next_err;                           // RULE13
      end
   end

   // switches take effect one cycle after they settle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         node_addr_o     <= `IMRM_ADDR_RESET;
         addr_from_mem_o <= 1'b1;
      end else begin
         node_addr_o     <= next_node;                      // RULE12
         addr_from_mem_o <= sw_off;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_type_o  <= `IMRM_INTYPE_RESET;
         filter_o      <= `IMRM_FILTER_RESET;
         cj_comp_o     <= `IMRM_CJ_RESET;
         reject_o      <= IMRM_REJ_50;
         force_fault_o <= 1'b0;
      end else begin
         input_type_o  <= in_type;
         filter_o      <= filt;
         cj_comp_o     <= cj_en;
         reject_o      <= imrm_reject_t'(rej);              // RULE7
         force_fault_o <= next_force;                       // RULE8
      end
   end
endmodule : imrm_regs
`default_nettype wire

//--- verification/imrm_regs_asserts.sv
// checker for the register port and status paths of imrm_regs
// assumes bind onto imrm_regs, a single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "imrm_defines.svh"
module imrm_regs_asserts
   import imrm_pkg::*;
(
   // clock, reset, register port
   input wire logic        ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i,
   input wire logic [15:0] reg_addr_i,
   input wire imrm_word_t  reg_wdata_i, reg_rdata_o,
   input wire logic        reg_ack_o, reg_err_o,
   // status and address
   input wire logic [5:0]  addr_sw_i,
   input wire logic        over_hw_i, mem_loss_i, addr_from_mem_o,
   input wire logic [7:0]  node_addr_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire rd_err = reg_rd_i && reg_addr_i == `IMRM_OFF_ERR;
   property p_ack; reg_wr_i || reg_rd_i |=> reg_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack after strobe");
   property p_noack; !(reg_wr_i || reg_rd_i) |=> !reg_ack_o; endproperty
   a_noack: assert property (p_noack) else $error("stray ack");
   property p_errack; reg_err_o |-> reg_ack_o; endproperty
   a_errack: assert property (p_errack) else $error("err without ack");
   property p_ro; reg_wr_i && reg_addr_i == `IMRM_OFF_IDENT |=> reg_err_o;
   endproperty
   a_ro: assert property (p_ro) else $error("identity write taken");
   property p_rdz; !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
   a_rdz: assert property (p_rdz) else $error("read data not idle");
   property p_over; over_hw_i [*3] ##0 rd_err |=> reg_rdata_o[5];
   endproperty
   a_over: assert property (p_over) else $error("bit 5 missing");
   property p_mem; mem_loss_i [*3] ##0 rd_err |=> reg_rdata_o[0];
   endproperty
   a_mem: assert property (p_mem) else $error("bit 0 missing");
   property p_rej3; reg_wr_i && reg_addr_i == `IMRM_OFF_REJECT &&
      reg_wdata_i[9:8] == 2'h3 |=> reg_err_o; endproperty
   a_rej3: assert property (p_rej3) else $error("code 11 taken");
   property p_sw; addr_sw_i != 6'h00 |=>
      !addr_from_mem_o && node_addr_o == {2'h0, $past(addr_sw_i)};
   endproperty
   a_sw: assert property (p_sw) else $error("switch address lost");
   c_wrerr: cover property (reg_wr_i ##1 reg_err_o);
   c_errw: cover property (rd_err ##1 reg_rdata_o != 16'h0000);
   c_mem: cover property (addr_from_mem_o ##1 !addr_from_mem_o);
endmodule : imrm_regs_asserts
bind imrm_regs imrm_regs_asserts i_imrm_regs_asserts (.ref_clk_i, .rst_n_i,
   .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
   .reg_err_o, .addr_sw_i, .over_hw_i, .mem_loss_i, .addr_from_mem_o,
   .node_addr_o);
`default_nettype wire

//--- verification/imrm_master.sv
// bus master model issuing single-word register accesses
// assumes strobes taken on the rising edge, answer one cycle later
`timescale 1ns/100ps
`default_nettype none
module imrm_master
   import imrm_pkg::*;
(
   input wire logic         ref_clk_i,
   output var logic         reg_wr_o,
   output var logic         reg_rd_o,
   output var logic [15:0]  reg_addr_o,
   output imrm_word_t       reg_wdata_o,
   input wire imrm_word_t   reg_rdata_i,
   input wire logic         reg_err_i
);
   initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
   // released address and data lines show the inverse, never a stale copy
   task automatic acc(input logic w, input logic [15:0] a, d,
                      output imrm_word_t q, output logic e);
      @(negedge ref_clk_i);
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
      @(negedge ref_clk_i);
      {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
      q = reg_rdata_i;
      e = reg_err_i;
   endtask : acc
endmodule : imrm_master
`default_nettype wire

//--- verification/test_input_module_register_map.sv
// self-checking bench for the input module register bank
// assumes imrm_regs, the master model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "imrm_defines.svh"
module test_input_module_register_map;
   import imrm_pkg::*;
   logic ref_clk_i = 0, rst_n_i = 0, fault_i = 0, mem_load_i = 0, e;
   logic over_hw_i = 0, below_ss_i = 0, above_es_i = 0;
   logic cj_fail_i = 0, mem_loss_i = 0, reg_wr_i, reg_rd_i, reg_ack_o;
   logic reg_err_o, addr_from_mem_o, cj_comp_o, force_fault_o;
   logic [5:0] addr_sw_i = 0;
   logic [7:0] mem_addr_i = 0, node_addr_o, filter_o;
   logic [15:0] reg_addr_i, input_type_o;
   imrm_word_t reg_wdata_i, reg_rdata_o, q;
   imrm_reject_t reject_o;
   int bad_count = 0, n_tests = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   imrm_regs i_imrm_regs (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
      .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_err_o,
      .addr_sw_i, .mem_addr_i, .mem_load_i, .over_hw_i, .below_ss_i,
      .above_es_i, .cj_fail_i, .mem_loss_i, .fault_i, .node_addr_o,
      .addr_from_mem_o, .input_type_o, .filter_o, .cj_comp_o, .reject_o,
      .force_fault_o);
   imrm_master i_imrm_master (.ref_clk_i, .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
      .reg_err_i(reg_err_o));
   task automatic chk(input string n, input logic [15:0] s, x);
      n_tests++;
      if (s !== x) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, d, input logic x);
      i_imrm_master.acc(1'b1, a, d, q, e);
      chk("write err", {15'h0, e}, {15'h0, x});
   endtask : wr
   task automatic rd(input logic [15:0] a, x);
      i_imrm_master.acc(1'b0, a, 16'h0000, q, e);
      chk("read data", q, x);
   endtask : rd
   task automatic st(input logic [4:0] s, input logic [15:0] x);
      @(negedge ref_clk_i);
      {over_hw_i, below_ss_i, above_es_i, cj_fail_i, mem_loss_i} = s;
      repeat (3) @(negedge ref_clk_i);
      rd(`IMRM_OFF_ERR, x);
   endtask : st
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd(`IMRM_OFF_IDENT, {`IMRM_TYPE_CODE, `IMRM_MOD_VERSION});
      rd(`IMRM_OFF_FW, `IMRM_FW_CODE);
      rd(`IMRM_OFF_INTYPE, 16'h0000);
      rd(`IMRM_OFF_FILTER, 16'h0000);
      rd(`IMRM_OFF_REJECT, 16'h0000);
      rd(`IMRM_OFF_ADDR, 16'h0100);
      chk("node", node_addr_o, 16'h0001);
      $display("reset values done");
   endtask : t_reset
   task automatic t_ro;
      wr(`IMRM_OFF_IDENT, 16'hFFFF, 1'b1);
      wr(`IMRM_OFF_FW, 16'h0000, 1'b1);
      wr(`IMRM_OFF_ERR, 16'hFFFF, 1'b1);
      wr(16'h9C44, 16'h0001, 1'b1);
      rd(`IMRM_OFF_FW, `IMRM_FW_CODE);
      $display("read-only done");
   endtask : t_ro
   task automatic t_rej;
      for (int i = 0; i < 3; i++) begin
         wr(`IMRM_OFF_REJECT, {6'h3F, i[1:0], 8'h01}, 1'b0);
         @(negedge ref_clk_i);
         chk("reject", reject_o, i[15:0]);
      end
      wr(`IMRM_OFF_REJECT, 16'h0301, 1'b1);
      rd(`IMRM_OFF_REJECT, 16'h0201);
      fault_i = 1;
      @(negedge ref_clk_i);
      chk("force", force_fault_o, 16'h0001);
      fault_i = 0;
      $display("rejection done");
   endtask : t_rej
   task automatic t_cfg;
      wr(`IMRM_OFF_FILTER, 16'h0113, 1'b0);
      wr(`IMRM_OFF_FILTER, 16'h0014, 1'b1);
      wr(`IMRM_OFF_INTYPE, 16'h0017, 1'b0);
      wr(`IMRM_OFF_INTYPE, 16'h0018, 1'b1);
      @(negedge ref_clk_i);
      chk("filter", {filter_o, 7'h0, cj_comp_o}, 16'h1301);
      chk("type", input_type_o, 16'h0017);
      $display("config done");
   endtask : t_cfg
   task automatic t_err;
      st(5'b10000, 16'h0020);
      st(5'b01000, 16'h0014);
      st(5'b00100, 16'h000C);
      st(5'b00001, 16'h0001);
      st(5'b00010, 16'h0000);
      wr(`IMRM_OFF_INTYPE, 16'h0003, 1'b0);
      st(5'b00010, 16'h0002);
      wr(`IMRM_OFF_REJECT, 16'h0000, 1'b0);
      fault_i = 1;
      @(negedge ref_clk_i);
      chk("force off", force_fault_o, 16'h0000);
      fault_i = 0;
      st(5'b01000, 16'h0010);
      st(5'b00000, 16'h0000);
      $display("error word done");
   endtask : t_err
   task automatic t_addr;
      addr_sw_i = 6'h05;
      repeat (2) @(negedge ref_clk_i);
      chk("sw node", node_addr_o, 16'h0005);
      chk("sw source", addr_from_mem_o, 16'h0000);
      addr_sw_i = 6'h00;
      mem_addr_i = 8'h22;
      mem_load_i = 1;
      @(negedge ref_clk_i);
      mem_load_i = 0;
      rd(`IMRM_OFF_ADDR, 16'h2200);
      wr(`IMRM_OFF_ADDR, 16'h0000, 1'b1);
      wr(`IMRM_OFF_ADDR, 16'hFF00, 1'b0);
      @(negedge ref_clk_i);
      chk("mem node", node_addr_o, 16'h00FF);
      chk("mem source", addr_from_mem_o, 16'h0001);
      $display("address done");
   endtask : t_addr
   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_n_i = 1;
      t_reset();
      t_ro();
      t_rej();
      t_cfg();
      t_err();
      t_addr();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      bad_count++;
      end_sim();
   end
endmodule : test_input_module_register_map
`default_nettype wire
